//--- adc_defines.svh
// register offsets, field positions, reset values, channel codes and response codes of the converter control
`ifndef ADC_DEFINES_SVH
`define ADC_DEFINES_SVH

// register byte addresses on the bus
`define OFF_STATUS_CONTROL 8'h00
`define OFF_RESULT_HIGH 8'h04
`define OFF_RESULT_LOW 8'h08
`define OFF_PIN_ENABLES 8'h0c
`define OFF_CONFIG 8'h10

// status/control field positions
`define SC_DONE_BIT 7
`define SC_IRQ_EN_BIT 6
`define SC_CONT_BIT 5
`define SC_CHAN_MSB 4
`define SC_CHAN_LSB 0

// configuration field positions
`define CFG_EIGHT_BIT_SELECT_BIT 7
`define CFG_SGN_BIT 6
`define CFG_DJM_BIT 5
`define CFG_PRS_MSB 3
`define CFG_PRS_LSB 0

// reset values
`define SC_RESET 5'h1f
`define PE_RESET 8'h00
`define CFG_RESET 8'h00

// channel codes
`define CHAN_LAST_PIN 5'h07
`define CHAN_REF_HIGH 5'h1e
`define CHAN_REF_LOW 5'h1f

// axi response codes
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

//--- adc_pkg.sv
// types shared by the converter control files
package adc_pkg;

  typedef enum logic [2:0]
  {
    CONV_IDLE = 3'b001,
    CONV_BUSY = 3'b010,
    CONV_WAIT_START = 3'b100
  } conv_state_t;

endpackage

//--- conv_clock_divider.sv
// prescaler producing the conversion clock enable pulse
`timescale 1ns/1ps

module conv_clock_divider
  import adc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic clear_i,
  input wire logic [3:0] prescale_i,
  output logic tick_o
);

  typedef struct packed
  {
    logic [4:0] count;
    logic tick;
  } div_state_t;

  div_state_t st;
  div_state_t next_st;

  // one tick every (prescale+1)*2 bus cycles
  always_comb
  begin
    next_st = st;
    next_st.tick = 1'b0;
    if (clear_i)
    begin
      next_st.count = 5'h00;
    end
    else if (st.count >= {prescale_i, 1'b1})
    begin
      next_st.count = 5'h00;
      next_st.tick = 1'b1;
    end
    else
    begin
      next_st.count = st.count + 5'h01;
    end
  end

  // registered state
  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign tick_o = st.tick;

endmodule

//--- adc_control_result_logic.sv
// converter control, result formatting and axi4-lite register slave
//
// The address map and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`include "adc_defines.svh"

// Functional notes
// - writing status/control clears done, drops interrupt, starts new conversion
// - done flag is read-only and set at every conversion end
// - reading either result register clears the done flag
// - irq enable raises interrupt while done set; results already updated
// - system reset removes any pending interrupt
// - continuous mode restarts conversions back to back, updating results each time
// - single mode converts once per status/control write then idles
// - channel codes 00 to 07 select analog inputs zero to seven
// - codes 08-1d and 1f convert low reference, 1e high reference
// - left justified: result 9-2 in high 7-0, 1-0 in low 7-6
// - right justified: result 9-8 in high 1-0, 7-0 in low
// - eight-bit mode: result in high byte, low byte reads zero
// - ten-bit mode: the six unused result bits read zero
// - result registers are read-only, writes ignored
// - pin enable write aborts conversion without starting another
// - disabled pin converts low reference, giving an all-zero raw sample
// - pin enable register has one bit per pin, 1 dedicates to converter
// - signed left-justified output inverts the result msb
// - signed selection ignored in right-justified format
// - conversion clock is bus clock divided by twice (prescale plus one)
module adc_control_result_logic
  import adc_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic core_start_o,
  output logic [4:0] core_channel_o,
  output logic core_ref_high_o,
  output logic core_ref_low_o,
  output logic core_clk_en_o,
  input wire logic core_done_i,
  input wire logic [9:0] core_result_i,
  output logic [7:0] pin_analog_mode_o,
  output logic irq_o
);

  typedef struct packed
  {
    conv_state_t conv;
    logic done_flag;
    logic irq_en;
    logic cont;
    logic [4:0] chan;
    logic [7:0] pin_en;
    logic [7:0] cfg;
    logic [9:0] raw;
    logic [7:0] res_high;
    logic [7:0] res_low;
    logic start;
    logic have_aw;
    logic [7:0] awaddr;
    logic have_w;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ctrl_state_t;

  ctrl_state_t st;
  ctrl_state_t next_st;
  logic tick;
  logic do_write;
  logic do_read;
  logic sc_write;
  logic pe_write;
  logic res_read;
  logic pin_selected;
  logic pin_disabled;
  logic [9:0] eff_raw;
  logic [9:0] fmt_src;
  logic [7:0] fmt_high;
  logic [7:0] fmt_low;

  conv_clock_divider u_div
  (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .clear_i(sc_write),
    .prescale_i(st.cfg[`CFG_PRS_MSB:`CFG_PRS_LSB]),
    .tick_o(tick)
  );

  // bus transfer decode: write fires once address and data are both held
  assign do_write = st.have_aw && st.have_w && !st.bvalid;
  assign do_read = s_axi_arvalid_i && !st.rvalid;
  assign sc_write = do_write && st.awaddr == `OFF_STATUS_CONTROL && st.wstrb[0];
  assign pe_write = do_write && st.awaddr == `OFF_PIN_ENABLES && st.wstrb[0];
  assign res_read = do_read && (s_axi_araddr_i == `OFF_RESULT_HIGH || s_axi_araddr_i == `OFF_RESULT_LOW);

  // pins 0-7 need their enable bit, else low reference
  assign pin_selected = st.chan <= `CHAN_LAST_PIN;
  assign pin_disabled = pin_selected && !st.pin_en[st.chan[2:0]];
  assign eff_raw = pin_disabled ? 10'h000 : core_result_i;
  // format the sample being latched, so results land on the same edge as done
  assign fmt_src = (st.conv == CONV_BUSY && core_done_i) ? eff_raw : st.raw;

  // result formatting from the sample being latched or the held one
  always_comb
  begin
    fmt_high = 8'h00;
    fmt_low = 8'h00;
    if (st.cfg[`CFG_EIGHT_BIT_SELECT_BIT])
    begin
      // eight-bit result lives in the high byte
      fmt_high = fmt_src[9:2];
      if (!st.cfg[`CFG_DJM_BIT] && st.cfg[`CFG_SGN_BIT])
      begin
        fmt_high[7] = ~fmt_src[9];
      end
    end
    else if (!st.cfg[`CFG_DJM_BIT])
    begin
      fmt_high = fmt_src[9:2];
      fmt_low = {fmt_src[1:0], 6'h00};
      if (st.cfg[`CFG_SGN_BIT])
      begin
        fmt_high[7] = ~fmt_src[9];
      end
    end
    else
    begin
      fmt_high = {6'h00, fmt_src[9:8]};
      fmt_low = fmt_src[7:0];
    end
  end

  // next-state logic for bus slave, registers and conversion sequencer
  always_comb
  begin
    next_st = st;
    next_st.start = 1'b0;
    // capture write address and data independently, in either order
    if (s_axi_awvalid_i && !st.have_aw)
    begin
      next_st.have_aw = 1'b1;
      next_st.awaddr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && !st.have_w)
    begin
      next_st.have_w = 1'b1;
      next_st.wdata = s_axi_wdata_i;
      next_st.wstrb = s_axi_wstrb_i;
    end
    if (st.bvalid && s_axi_bready_i)
    begin
      next_st.bvalid = 1'b0;
    end
    if (st.rvalid && s_axi_rready_i)
    begin
      next_st.rvalid = 1'b0;
    end
    // conversion sequencer
    unique case (st.conv)
      CONV_IDLE:
      begin
      end
      CONV_WAIT_START:
      begin
        // start strobe aligned to a conversion clock tick
        if (tick)
        begin
          next_st.start = 1'b1;
          next_st.conv = CONV_BUSY;
        end
      end
      CONV_BUSY:
      begin
        if (core_done_i)
        begin
          next_st.raw = eff_raw;
          // hardware sets done at each conversion end
          next_st.done_flag = 1'b1;
          next_st.conv = st.cont ? CONV_WAIT_START : CONV_IDLE;
        end
      end
    endcase
    // result read clears done; a completing conversion wins
    if (res_read && !(st.conv == CONV_BUSY && core_done_i))
    begin
      next_st.done_flag = 1'b0;
    end
    if (do_write)
    begin
      next_st.have_aw = 1'b0;
      next_st.have_w = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = `RESP_OKAY;
      unique case (st.awaddr)
        `OFF_STATUS_CONTROL:
        begin
          if (st.wstrb[0])
          begin
            // clear done, drop irq, start a fresh conversion
            next_st.irq_en = st.wdata[`SC_IRQ_EN_BIT];
            next_st.cont = st.wdata[`SC_CONT_BIT];
            next_st.chan = st.wdata[`SC_CHAN_MSB:`SC_CHAN_LSB];
            next_st.done_flag = 1'b0;
            next_st.conv = CONV_WAIT_START;
            // a start launched now would belong to the cancelled conversion
            next_st.start = 1'b0;
          end
        end
        `OFF_PIN_ENABLES:
        begin
          if (st.wstrb[0])
          begin
            next_st.pin_en = st.wdata[7:0];
            // abort without restarting, even on a start tick
            next_st.conv = CONV_IDLE;
            next_st.start = 1'b0;
          end
        end
        `OFF_CONFIG:
        begin
          if (st.wstrb[0])
          begin
            next_st.cfg = st.wdata[7:0];
          end
        end
        `OFF_RESULT_HIGH, `OFF_RESULT_LOW:
        begin
        end
        default:
        begin
          next_st.bresp = `RESP_SLVERR;
        end
      endcase
    end
    if (do_read)
    begin
      next_st.rvalid = 1'b1;
      next_st.rresp = `RESP_OKAY;
      next_st.rdata = 32'h0000_0000;
      unique case (s_axi_araddr_i)
        `OFF_STATUS_CONTROL:
        begin
          next_st.rdata[7:0] = {st.done_flag, st.irq_en, st.cont, st.chan};
        end
        `OFF_RESULT_HIGH:
        begin
          next_st.rdata[7:0] = st.res_high;
        end
        `OFF_RESULT_LOW:
        begin
          next_st.rdata[7:0] = st.res_low;
        end
        `OFF_PIN_ENABLES:
        begin
          next_st.rdata[7:0] = st.pin_en;
        end
        `OFF_CONFIG:
        begin
          next_st.rdata[7:0] = st.cfg;
        end
        default:
        begin
          next_st.rresp = `RESP_SLVERR;
        end
      endcase
    end
    // result registers follow the raw sample and current format
    next_st.res_high = fmt_high;
    next_st.res_low = st.cfg[`CFG_EIGHT_BIT_SELECT_BIT] ? 8'h00 : fmt_low;
  end

  // synchronous reset clears state, pending interrupt included, except sequencer (loaded with CONV_IDLE) and channel code (loaded with 1f)
  always_ff @(posedge clk_sys_i)
  begin
    if (!nrst_i)
    begin
      st <= '0;
      st.conv <= CONV_IDLE;
      st.chan <= `SC_RESET;
      st.pin_en <= `PE_RESET;
      st.cfg <= `CFG_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  // bus handshakes
  assign s_axi_awready_o = !st.have_aw;
  assign s_axi_wready_o = !st.have_w;
  assign s_axi_bvalid_o = st.bvalid;
  assign s_axi_bresp_o = st.bresp;
  assign s_axi_arready_o = !st.rvalid;
  assign s_axi_rvalid_o = st.rvalid;
  assign s_axi_rdata_o = st.rdata;
  assign s_axi_rresp_o = st.rresp;

  // reference routing for reserved codes and disabled pins
  assign core_start_o = st.start;
  assign core_channel_o = st.chan;
  assign core_ref_high_o = st.chan == `CHAN_REF_HIGH;
  assign core_ref_low_o = (!pin_selected && st.chan != `CHAN_REF_HIGH) || pin_disabled;
  assign core_clk_en_o = tick;
  assign pin_analog_mode_o = st.pin_en;

  assign irq_o = st.done_flag && st.irq_en;

endmodule

//--- adc_props.sv
// port assertions for the converter control block
`timescale 1ns/1ps
`include "adc_defines.svh"

module adc_props (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic core_start_o,
  input wire logic [4:0] core_channel_o,
  input wire logic core_ref_high_o,
  input wire logic core_ref_low_o,
  input wire logic core_clk_en_o,
  input wire logic [7:0] pin_analog_mode_o,
  input wire logic irq_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  // ==========
  // helpers
  logic wr_go;
  // address and data taken on the same edge
  assign wr_go = s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  // ==========
  // properties
  property p_start_pulse; core_start_o |=> !core_start_o; endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("start strobe too long");
  property p_tick_pulse; core_clk_en_o |=> !core_clk_en_o; endproperty
  a_tick_pulse: assert property (p_tick_pulse)
    else $error("clock enable too long");
  // reset must win even while asserted
  property p_irq_reset; disable iff (1'b0) !nrst_i |=> !irq_o; endproperty
  a_irq_reset: assert property (p_irq_reset)
    else $error("irq survives reset");
  property p_ref_high; core_channel_o == `CHAN_REF_HIGH |-> core_ref_high_o && !core_ref_low_o; endproperty
  a_ref_high: assert property (p_ref_high)
    else $error("high reference not chosen");
  property p_ref_low; core_channel_o[4:3] != 2'b00 && core_channel_o != 5'h1e |-> core_ref_low_o; endproperty
  a_ref_low: assert property (p_ref_low)
    else $error("low reference not chosen");
  property p_pin_sel;
    core_channel_o < 5'h08 |-> core_ref_low_o == !pin_analog_mode_o[core_channel_o[2:0]] && !core_ref_high_o;
  endproperty
  a_pin_sel: assert property (p_pin_sel)
    else $error("pin routing wrong");
  property p_irq_drop; irq_o && wr_go && s_axi_awaddr_i == `OFF_STATUS_CONTROL |-> ##[1:2] !irq_o; endproperty
  a_irq_drop: assert property (p_irq_drop)
    else $error("irq kept after control write");
  // window ends before a status write issued right after the response could start
  property p_pe_abort; wr_go && s_axi_awaddr_i == `OFF_PIN_ENABLES |-> ##2 !core_start_o [*5]; endproperty
  a_pe_abort: assert property (p_pe_abort)
    else $error("start after pin enable write");
endmodule

//--- analog_core_model.sv
// behavioural analog core answering start strobes
`timescale 1ns/1ps

module analog_core_model (
  input wire logic clk_sys_i,
  input wire logic start_i,
  input wire logic ref_high_i,
  input wire logic ref_low_i,
  input wire logic slow_i,
  input wire logic [9:0] pin_val_i,
  output logic done_o,
  output logic [9:0] result_o
);
  int cnt = 0;
  initial
  begin
    done_o = 1'b0;
    result_o = 10'h155;
  end
  // ==========
  // conversion, prompt or slow; result lines toggle outside done
  always @(posedge clk_sys_i)
  begin
    done_o <= 1'b0;
    result_o <= ~result_o;
    if (start_i)
      cnt <= slow_i ? 23 : 3;
    else if (cnt > 0)
    begin
      cnt <= cnt - 1;
      if (cnt == 1)
      begin
        done_o <= 1'b1;
        result_o <= ref_high_i ? 10'h3ff : (ref_low_i ? 10'h000 : pin_val_i);
      end
    end
  end
endmodule

//--- adc_control_result_logic_tb_top.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
`include "adc_defines.svh"

module adc_control_result_logic_tb_top;
  logic clk = 0, nrst = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, slow = 0;
  logic [7:0] awa = 0, ara = 0, cfg, pe;
  logic [31:0] wd = 0, d;
  logic [9:0] pv = 0, raw, cres;
  logic [4:0] ch, chan;
  logic [15:0] f;
  logic [1:0] r, br, rr;
  logic aw_rdy, w_rdy, bv, ar_rdy, rv, st, rh, rl, cen, cdone, irq;
  logic [31:0] rdat;
  logic [7:0] pam;
  int seed, i, n, nst = 0, cyc = 0, bad_count = 0, checks_done = 0;

  adc_control_result_logic i_adc_control_result_logic (.clk_sys_i(clk), .nrst_i(nrst), .s_axi_awaddr_i(awa),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(aw_rdy), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf),
    .s_axi_wvalid_i(wv), .s_axi_wready_o(w_rdy), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(bre),
    .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(ar_rdy), .s_axi_rdata_o(rdat),
    .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rre), .core_start_o(st), .core_channel_o(chan),
    .core_ref_high_o(rh), .core_ref_low_o(rl), .core_clk_en_o(cen), .core_done_i(cdone),
    .core_result_i(cres), .pin_analog_mode_o(pam), .irq_o(irq));
  analog_core_model i_analog_core_model (.clk_sys_i(clk), .start_i(st), .ref_high_i(rh), .ref_low_i(rl),
    .slow_i(slow), .pin_val_i(pv), .done_o(cdone), .result_o(cres));

  // ==========
  // clock, start count and hang limit
  always #5 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (st)
      nst++;
    if (cyc == 60000)
    begin
      bad_count++;
      complete_run();
    end
  end

  // ==========
  // expected byte pair from raw result and format bits
  function automatic logic [15:0] fmt(input logic [9:0] v, input logic [7:0] c);
    if (!c[5] && c[6])
      v[9] = ~v[9];
    if (c[7])
      return {v[9:2], 8'h00};
    return c[5] ? {6'h00, v} : {v, 6'h00};
  endfunction

  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] s);
    checks_done++;
    if (s !== e)
    begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask

  // bus write, address and data offered together; bready stays up between transfers
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic ta, tw;
    ta = 0;
    tw = 0;
    awa <= a;
    wd <= {24'h0, v};
    awv <= 1;
    wv <= 1;
    bre <= 1;
    while (!(ta && tw))
    begin
      @(posedge clk);
      if (!ta && aw_rdy)
      begin
        ta = 1;
        awv <= 0;
      end
      if (!tw && w_rdy)
      begin
        tw = 1;
        wv <= 0;
      end
    end
    while (!bv)
      @(posedge clk);
    r = br;
  endtask

  // cycles between two conversion clock enables
  task automatic tick_gap(input logic [3:0] p);
    n = 0;
    while (!cen && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (!cen && n < 100);
    chk("tick period", 34'((int'(p) + 1) * 2), 34'(n));
  endtask

  task automatic rd(input logic [7:0] a);
    ara <= a;
    arv <= 1;
    rre <= 1;
    do @(posedge clk); while (!ar_rdy);
    arv <= 0;
    do @(posedge clk); while (!rv);
    d = rdat;
    r = rr;
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] e, input string nm);
    rd(a);
    chk(nm, {`RESP_OKAY, 24'h0, e}, {r, d});
  endtask

  task automatic wait_irq();
    n = 0;
    while (irq !== 1'b1 && n < 600)
    begin
      @(posedge clk);
      n++;
    end
    chk("irq", 34'h1, {33'h0, irq});
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ==========
  // main sequence
  initial
  begin
    seed = 59;
    repeat (5) @(posedge clk);
    nrst <= 1;
    @(posedge clk);
    rc(`OFF_STATUS_CONTROL, 8'h1f, "sc reset");
    rc(`OFF_PIN_ENABLES, 8'h00, "pe reset");
    rd(8'h14);
    chk("unmapped", {`RESP_SLVERR, 32'h0}, {r, d});
    wr(8'h14, 8'h00);
    chk("unmapped write", {32'h0, `RESP_SLVERR}, {32'h0, r});
    $display("reset test done");
    // every channel code, random format and pins
    for (i = 0; i < 40; i++)
    begin
      cfg = $random(seed);
      pe = $random(seed);
      pv <= $random(seed);
      slow <= $random(seed);
      ch = (i < 32) ? i[4:0] : 5'($random(seed));
      wr(`OFF_CONFIG, cfg);
      tick_gap(cfg[3:0]);
      wr(`OFF_PIN_ENABLES, pe);
      raw = (ch == 5'h1e) ? 10'h3ff : ((ch < 5'h08 && pe[ch[2:0]]) ? pv : 10'h000);
      f = fmt(raw, cfg);
      nst = 0;
      wr(`OFF_STATUS_CONTROL, {3'b010, ch});
      wait_irq();
      rc(`OFF_STATUS_CONTROL, {3'b110, ch}, "done set");
      rc(`OFF_RESULT_HIGH, f[15:8], "high");
      chk("irq cleared", 34'h0, {33'h0, irq});
      wr(`OFF_RESULT_HIGH, 8'($random(seed)));
      chk("ro write resp", {32'h0, `RESP_OKAY}, {32'h0, r});
      rc(`OFF_RESULT_HIGH, f[15:8], "high ro");
      rc(`OFF_RESULT_LOW, f[7:0], "low");
      repeat (40) @(posedge clk);
      chk("single", 34'h1, 34'(nst));
    end
    $display("channel test done");
    // continuous, right justified, then abort
    pv <= 10'h2a5;
    wr(`OFF_PIN_ENABLES, 8'hff);
    wr(`OFF_CONFIG, 8'h20);
    nst = 0;
    wr(`OFF_STATUS_CONTROL, 8'h63);
    n = 0;
    while (nst < 3 && n < 900)
    begin
      @(posedge clk);
      n++;
    end
    chk("back to back", 34'h1, {33'h0, nst >= 3});
    rc(`OFF_RESULT_HIGH, 8'h02, "right high");
    rc(`OFF_RESULT_LOW, 8'ha5, "right low");
    wait_irq();
    wr(`OFF_STATUS_CONTROL, 8'h63);
    chk("irq withdrawn", 34'h0, {33'h0, irq});
    wr(`OFF_PIN_ENABLES, 8'hff);
    n = nst;
    repeat (60) @(posedge clk);
    chk("abort", 34'(n), 34'(nst));
    $display("continuous test done");
    // reset with a pending request
    wr(`OFF_STATUS_CONTROL, 8'h43);
    wait_irq();
    nrst <= 0;
    repeat (5) @(posedge clk);
    chk("irq after reset", 34'h0, {33'h0, irq});
    nrst <= 1;
    rc(`OFF_STATUS_CONTROL, 8'h1f, "sc after reset");
    $display("reset irq test done");
    complete_run();
  end
endmodule

bind adc_control_result_logic adc_props i_adc_props (.*);
